// file: hw/ncs_sequencer.sv
/*
 * nvm command sequencer: three-step command protocol, program timing
 * clock divider, command processor with burst and sector erase abort.
 * assumes processor-bus strobes are one-cycle pulses on clock.
 */
`timescale 1ns/1ps
`include "ncs_consts.svh"

// Summary of operation
// - divider accepts one write after reset
// - pulses timed in whole timing clock periods
// - byte 9 periods, burst and abort 4
// - sector erase 4000, mass erase 20000
// - array write latches address and data first
// - flash and eeprom erase independently
// - codes 05 blank, 20 byte, 25 burst
// - codes 40 sector, 41 mass, 47 abort
// - writing one to buffer empty launches
// - writing zero cancels sequence, sets access error
// - complete flag sets when a command finishes with none queued
// - pump stays on for queued same-block burst
// - first or new-block burst byte takes byte time
// - no queued burst turns pump off
// - abort is array write, 47, launch
// - cut erase sets access error with complete
// - erase finishing normally leaves access error clear
// - abort keeps buffer empty clear; new sequence errors
// - access error cleared by one; blocks commands
// - unknown command code sets access error
// - early or busy array write sets access error
module ncs_sequencer (
	input wire logic clock,
	input wire logic rst,
	input wire logic array_wr,
	input wire logic array_eeprom,
	input wire logic [16:0] array_addr,
	input wire logic [7:0] array_data,
	input wire logic div_wr,
	input wire logic [7:0] div_data,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_data,
	input wire logic stat_wr,
	input wire logic stat_cbef_wdata,
	input wire logic stat_access_error_wdata,
	input wire logic ctrl_access,
	input wire logic stop_entry,
	output ncs_pkg::ncs_status_t status,
	output logic [7:0] clock_divider_reg,
	output ncs_pkg::ncs_op_t exec_op,
	output logic exec_busy,
	output logic pump_on,
	output logic timing_tick
);

	function automatic logic code_ok(input logic [7:0] c);
		code_ok = (c == `NCS_CMD_BLANK) || (c == `NCS_CMD_BYTE) ||
			(c == `NCS_CMD_BURST) || (c == `NCS_CMD_SECT) ||
			(c == `NCS_CMD_MASS) || (c == `NCS_CMD_ABORT);
	endfunction : code_ok

	function automatic logic same_block(input ncs_pkg::ncs_op_t a,
		input ncs_pkg::ncs_op_t b);
		same_block = (a.eeprom == b.eeprom) &&
			(a.addr[16:`NCS_BLOCK_LSB] == b.addr[16:`NCS_BLOCK_LSB]);
	endfunction : same_block

	function automatic logic [14:0] cmd_ticks(input logic [7:0] c,
		input logic fast);
		case (c)
			`NCS_CMD_BYTE: cmd_ticks = `NCS_TICKS_BYTE;
			`NCS_CMD_BURST: cmd_ticks = fast ? `NCS_TICKS_BURST : `NCS_TICKS_BYTE;
			`NCS_CMD_SECT: cmd_ticks = `NCS_TICKS_SECT;
			`NCS_CMD_MASS: cmd_ticks = `NCS_TICKS_MASS;
			`NCS_CMD_ABORT: cmd_ticks = `NCS_TICKS_ABORT;
			default: cmd_ticks = `NCS_TICKS_BLANK;
		endcase
	endfunction : cmd_ticks

	ncs_pkg::ncs_seq_t seq_reg;
	ncs_pkg::ncs_proc_t proc_reg;
	logic div_set_reg;
	logic [7:0] div_cnt_reg;
	logic tick_reg;
	logic cbef_reg;
	logic ccf_reg;
	logic access_error_reg;
	ncs_pkg::ncs_op_t latch_reg;
	ncs_pkg::ncs_op_t buf_reg;
	logic buf_full_reg;
	logic abort_req_reg;
	ncs_pkg::ncs_op_t cur_reg;
	logic [14:0] cnt_reg;
	logic cut_reg;
	logic keep_reg;
	logic pump_reg;

	// protocol decode
	wire blocked = access_error_reg;
	wire arr_ok = array_wr && !blocked && div_set_reg && cbef_reg &&
		seq_reg == ncs_pkg::SEQ_IDLE;
	wire arr_bad = array_wr && !arr_ok;
	wire cmd_ok = cmd_wr && !blocked && seq_reg == ncs_pkg::SEQ_ADDR &&
		code_ok(cmd_data);
	wire cmd_bad = cmd_wr && !blocked && seq_reg != ncs_pkg::SEQ_IDLE && !cmd_ok;
	wire launch = stat_wr && stat_cbef_wdata && !blocked &&
		seq_reg == ncs_pkg::SEQ_CMD;
	wire launch_abort = launch && latch_reg.cmd == `NCS_CMD_ABORT;
	wire launch_norm = launch && !launch_abort;
	wire cancel = stat_wr && !stat_cbef_wdata && !blocked &&
		seq_reg != ncs_pkg::SEQ_IDLE;
	wire ctrl_bad = ctrl_access && !blocked && seq_reg != ncs_pkg::SEQ_IDLE;
	wire acc_clr = stat_wr && stat_access_error_wdata;

	// processor decode
	wire running = proc_reg == ncs_pkg::PROC_RUN;
	wire stop_hit = stop_entry && running;
	wire done = running && tick_reg && cnt_reg == 15'h0001 && !stop_hit;
	wire is_sect = cur_reg.cmd == `NCS_CMD_SECT;
	wire cut_now = running && abort_req_reg && is_sect && !cut_reg &&
		cnt_reg > `NCS_TICKS_ABORT;
	wire take_buf = !running && buf_full_reg;
	wire take_abort = !running && !buf_full_reg && abort_req_reg;
	wire chain = cur_reg.cmd == `NCS_CMD_BURST && buf_full_reg &&
		buf_reg.cmd == `NCS_CMD_BURST && same_block(buf_reg, cur_reg);
	wire cut_done = done && cut_reg;
	wire pending = buf_full_reg || abort_req_reg;
	wire acc_set = arr_bad || cmd_bad || cancel || ctrl_bad || stop_hit ||
		cut_done;
	wire div_take = div_wr && !div_set_reg;

	// next values
	wire access_error_next = acc_set || (access_error_reg && !acc_clr);
	wire [7:0] div_cnt_next = (div_cnt_reg == clock_divider_reg) ? 8'h00 :
		div_cnt_reg + 8'h01;
	wire tick_next = div_set_reg && div_cnt_reg == clock_divider_reg;
	wire [14:0] cnt_dec = cnt_reg - 15'h0001;

	assign status = '{cbef: cbef_reg, ccf: ccf_reg, access_error_flag: access_error_reg,
		div_set: div_set_reg};
	assign exec_op = cur_reg;
	assign exec_busy = running;
	assign pump_on = pump_reg;
	assign timing_tick = tick_reg;

	// divider takes its first write only; later writes are dropped
	always_ff @(posedge clock) begin
		if (rst) begin
			div_set_reg <= 1'b0;
			clock_divider_reg <= `NCS_DIV_RST;
		end else if (div_take) begin
			div_set_reg <= 1'b1;
			clock_divider_reg <= div_data;
		end
	end

	// timing clock as a one-cycle strobe; avoids a derived clock net
	always_ff @(posedge clock) begin
		if (rst) begin
			div_cnt_reg <= 8'h00;
			tick_reg <= 1'b0;
		end else begin
			div_cnt_reg <= div_set_reg ? div_cnt_next : 8'h00;
			tick_reg <= tick_next;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			access_error_reg <= 1'b0;
		end else begin
			access_error_reg <= access_error_next;
		end
	end

	// command write sequence
	always_ff @(posedge clock) begin
		if (rst) begin
			seq_reg <= ncs_pkg::SEQ_IDLE;
			latch_reg <= '0;
		end else begin
			case (seq_reg)
				ncs_pkg::SEQ_IDLE: begin
					if (arr_ok) begin
						seq_reg <= ncs_pkg::SEQ_ADDR;
						latch_reg <= '{cmd: `NCS_CMD_RST, eeprom: array_eeprom,
							addr: array_addr, data: array_data};
					end
				end
				ncs_pkg::SEQ_ADDR: begin
					if (cmd_ok) begin
						seq_reg <= ncs_pkg::SEQ_CMD;
						latch_reg.cmd <= cmd_data;
					end else if (acc_set) begin
						seq_reg <= ncs_pkg::SEQ_IDLE;
					end
				end
				ncs_pkg::SEQ_CMD: begin
					if (launch || acc_set) begin
						seq_reg <= ncs_pkg::SEQ_IDLE;
					end
				end
				default: seq_reg <= ncs_pkg::SEQ_IDLE;
			endcase
		end
	end

	// buffer empty flag: cleared by launch, set once the processor takes it; after an abort, set when the abort or cut erase ends
	always_ff @(posedge clock) begin
		if (rst) begin
			cbef_reg <= 1'b1;
		end else if (take_buf || (done && cur_reg.cmd == `NCS_CMD_ABORT)) begin
			cbef_reg <= 1'b1;
		end else if (cut_done || stop_hit) begin
			cbef_reg <= 1'b1;
		end else if (launch) begin
			cbef_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			buf_full_reg <= 1'b0;
			buf_reg <= '0;
			abort_req_reg <= 1'b0;
		end else begin
			if (launch_norm) begin
				buf_full_reg <= 1'b1;
				buf_reg <= latch_reg;
			end else if (take_buf || stop_hit) begin
				buf_full_reg <= 1'b0;
			end
			if (launch_abort) begin
				abort_req_reg <= 1'b1;
			end else if (cut_now || take_abort || stop_hit) begin
				abort_req_reg <= 1'b0;
			end
		end
	end

	// complete flag: low from launch until nothing is left to run
	always_ff @(posedge clock) begin
		if (rst) begin
			ccf_reg <= 1'b1;
		end else if (launch) begin
			ccf_reg <= 1'b0;
		end else if (stop_hit || (done && !pending)) begin
			ccf_reg <= 1'b1;
		end
	end

	// command processor; erase acts on cur_reg.eeprom's array only
	always_ff @(posedge clock) begin
		if (rst) begin
			proc_reg <= ncs_pkg::PROC_IDLE;
			cur_reg <= '0;
			cnt_reg <= 15'h0000;
			cut_reg <= 1'b0;
		end else begin
			case (proc_reg)
				ncs_pkg::PROC_IDLE: begin
					if (take_buf) begin
						proc_reg <= ncs_pkg::PROC_RUN;
						cur_reg <= buf_reg;
						cnt_reg <= cmd_ticks(buf_reg.cmd, keep_reg);
						cut_reg <= 1'b0;
					end else if (take_abort) begin
						proc_reg <= ncs_pkg::PROC_RUN;
						cur_reg.cmd <= `NCS_CMD_ABORT;
						cnt_reg <= `NCS_TICKS_ABORT;
						cut_reg <= 1'b0;
					end
				end
				ncs_pkg::PROC_RUN: begin
					if (stop_hit || done) begin
						proc_reg <= ncs_pkg::PROC_IDLE;
					end else if (cut_now) begin
						cnt_reg <= `NCS_TICKS_ABORT;
						cut_reg <= 1'b1;
					end else if (tick_reg) begin
						cnt_reg <= cnt_dec;
					end
				end
				default: proc_reg <= ncs_pkg::PROC_IDLE;
			endcase
		end
	end

	// charge pump: held across a same-block burst queued before completion
	always_ff @(posedge clock) begin
		if (rst) begin
			pump_reg <= 1'b0;
			keep_reg <= 1'b0;
		end else if (stop_hit) begin
			pump_reg <= 1'b0;
			keep_reg <= 1'b0;
		end else if (done) begin
			pump_reg <= chain;
			keep_reg <= chain;
		end else if (take_buf || take_abort) begin
			pump_reg <= 1'b1;
			keep_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence seq_cut_end;
		done && cut_reg;
	endsequence

	sequence seq_flags_err;
		ccf_reg && access_error_reg;
	endsequence

	a_div_once_only: assert property (
		div_set_reg && div_wr |=> $stable(clock_divider_reg))
		else $error("divider changed after first write");
	a_bad_code_err: assert property (
		cmd_wr && !access_error_reg && seq_reg == ncs_pkg::SEQ_ADDR &&
		!code_ok(cmd_data) |=> access_error_reg)
		else $error("invalid code did not set access error");
	a_launch_clears_cbef: assert property (
		launch_norm && !take_buf |=> !cbef_reg && buf_full_reg && !ccf_reg)
		else $error("launch did not clear buffer empty");
	a_cancel_sets_err: assert property (
		cancel |=> access_error_reg && seq_reg == ncs_pkg::SEQ_IDLE)
		else $error("cancel did not set access error");
	a_abort_keeps_cbef: assert property (
		launch_abort |=> !cbef_reg)
		else $error("abort launch set buffer empty");
	a_early_write_err: assert property (
		array_wr && (!cbef_reg || !div_set_reg) |=> access_error_reg)
		else $error("illegal array write not flagged");
	a_count_on_tick: assert property (
		running && !tick_reg && !cut_now && !stop_hit |=> $stable(cnt_reg))
		else $error("count moved without timing clock");
	a_done_sets_ccf: assert property (
		done && !pending |=> ccf_reg && !exec_busy)
		else $error("complete flag not set at finish");
	a_cut_sets_err: assert property (
		seq_cut_end |=> seq_flags_err)
		else $error("cut erase did not report access error");
	a_normal_no_err: assert property (
		done && !cut_reg && !access_error_reg &&
		!(arr_bad || cmd_bad || cancel || ctrl_bad) |=> !access_error_reg)
		else $error("normal finish set access error");
	a_byte_nine: assert property (
		take_buf && buf_reg.cmd == `NCS_CMD_BYTE |=> cnt_reg == 15'h0009)
		else $error("byte program not nine periods");
	a_mass_length: assert property (
		take_buf && buf_reg.cmd == `NCS_CMD_MASS |=> cnt_reg == 15'h4E20)
		else $error("mass erase count wrong");
	a_pump_drops: assert property (
		done && !chain |=> !pump_on)
		else $error("pump left on without queued burst");
	a_burst_fast: assert property (
		take_buf && keep_reg && buf_reg.cmd == `NCS_CMD_BURST |=>
		cnt_reg == 15'h0004 ##1 pump_on)
		else $error("chained burst not short");

endmodule : ncs_sequencer

// file: hw/ncs_consts.svh
/*
 * constants of the nvm command sequencer: command codes, timing counts,
 * reset values and field positions.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef NCS_CONSTS_SVH
`define NCS_CONSTS_SVH

// command codes
`define NCS_CMD_BLANK 8'h05
`define NCS_CMD_BYTE 8'h20
`define NCS_CMD_BURST 8'h25
`define NCS_CMD_SECT 8'h40
`define NCS_CMD_MASS 8'h41
`define NCS_CMD_ABORT 8'h47

// program timing clock periods per command
`define NCS_TICKS_BYTE 15'h0009
`define NCS_TICKS_BURST 15'h0004
`define NCS_TICKS_SECT 15'h0FA0
`define NCS_TICKS_MASS 15'h4E20
`define NCS_TICKS_ABORT 15'h0004
`define NCS_TICKS_BLANK 15'h0001

// reset values
`define NCS_DIV_RST 8'h00
`define NCS_CMD_RST 8'h00

// burst block: address bits from this index up name a 32-byte block
`define NCS_BLOCK_LSB 5

`endif

// file: hw/ncs_pkg.sv
/*
 * types of the nvm command sequencer.
 * assumes ncs_consts.svh for all numeric constants.
 */
package ncs_pkg;

	typedef struct packed {
		logic [7:0] cmd;
		logic eeprom;
		logic [16:0] addr;
		logic [7:0] data;
	} ncs_op_t;

	typedef struct packed {
		logic cbef;
		logic ccf;
		logic access_error_flag;
		logic div_set;
	} ncs_status_t;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ADDR,
		SEQ_CMD
	} ncs_seq_t;

	typedef enum logic {
		PROC_IDLE,
		PROC_RUN
	} ncs_proc_t;

endpackage : ncs_pkg

// file: tb/ncs_cpu_model.sv
/*
 * processor bus model: issues array, divider, command and status writes.
 * assumes the sequencer takes each strobe on the rising edge of clock.
 */
`timescale 1ns/1ps
module ncs_cpu_model (
	input wire logic clock,
	output logic array_wr,
	output logic array_eeprom,
	output logic [16:0] array_addr,
	output logic [7:0] array_data,
	output logic div_wr,
	output logic [7:0] div_data,
	output logic cmd_wr,
	output logic [7:0] cmd_data,
	output logic stat_wr,
	output logic stat_cbef_wdata,
	output logic stat_access_error_wdata
);
	initial begin
		{array_wr, div_wr, cmd_wr, stat_wr} = 4'h0;
		{array_eeprom, array_addr, array_data, div_data, cmd_data} = 42'h0;
		{stat_cbef_wdata, stat_access_error_wdata} = 2'h0;
	end

	// k: 0 array, 1 divider, 2 command, 3 status (d[0] buffer empty, d[1] error clear)
	task automatic put(input logic [1:0] k, input logic [16:0] a, input logic [7:0] d,
		input logic e);
		@(negedge clock);
		{array_eeprom, array_addr, array_data, div_data, cmd_data} = {e, a, d, d, d};
		{stat_access_error_wdata, stat_cbef_wdata} = d[1:0];
		{array_wr, div_wr, cmd_wr, stat_wr} = 4'h8 >> k;
		@(negedge clock);
		{array_wr, div_wr, cmd_wr, stat_wr} = 4'h0;
		// qualifiers no longer hold once the strobe is gone
		{array_eeprom, array_addr, array_data, div_data, cmd_data} = ~{e, a, d, d, d};
		{stat_access_error_wdata, stat_cbef_wdata} = ~d[1:0];
	endtask : put
endmodule : ncs_cpu_model

// file: tb/tb_top.sv
/*
 * self-checking bench of the nvm command sequencer.
 * assumes divider 1, so one timing period is two clocks.
 */
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [7:0] cmd;
		logic [14:0] ticks;
		logic err;
		logic hold;
	} ncs_note_t;

	logic clock = 1'b0;
	logic rst = 1'b1;
	logic array_wr, array_eeprom, div_wr, cmd_wr, stat_wr;
	logic stat_cbef_wdata, stat_access_error_wdata, exec_busy, pump_on, timing_tick;
	logic ctrl_access = 1'b0, stop_entry = 1'b0;
	logic [16:0] array_addr;
	logic [7:0] array_data, div_data, cmd_data, clock_divider_reg, seen_cmd;
	ncs_pkg::ncs_status_t status;
	ncs_pkg::ncs_op_t exec_op;
	ncs_note_t notes[$];
	ncs_note_t n;
	int unsigned mismatches = 0, total_checks = 0, cycles = 0, ticks = 0;
	logic gap = 1'b0, ccf_q = 1'b1;

	always #2.5 clock = ~clock;

	ncs_cpu_model cpu (.clock, .array_wr, .array_eeprom, .array_addr, .array_data,
		.div_wr, .div_data, .cmd_wr, .cmd_data, .stat_wr, .stat_cbef_wdata,
		.stat_access_error_wdata);

	ncs_sequencer uut (.clock, .rst, .array_wr, .array_eeprom, .array_addr,
		.array_data, .div_wr, .div_data, .cmd_wr, .cmd_data, .stat_wr,
		.stat_cbef_wdata, .stat_access_error_wdata, .ctrl_access, .stop_entry,
		.status, .clock_divider_reg, .exec_op, .exec_busy, .pump_on, .timing_tick);

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task close_out;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	// f: 0 buffer empty, 1 complete; bounded wait on a flag
	task automatic wait_on(input logic f, input logic v);
		int unsigned i = 0;
		while ((f ? status.ccf : status.cbef) !== v && i < 50000) begin
			@(negedge clock);
			i++;
		end
		chk(f ? "ccf" : "cbef", f ? status.ccf : status.cbef, v);
	endtask : wait_on

	task automatic launch(input logic [7:0] c, input logic e, input logic [16:0] a,
		input logic [7:0] d);
		cpu.put(2'h0, a, d, e);
		cpu.put(2'h2, a, c, e);
		cpu.put(2'h3, a, 8'h01, e);
	endtask : launch

	task automatic settle_err(input logic v);
		repeat (2) @(negedge clock);
		chk("access error", status.access_error_flag, v);
	endtask : settle_err

	// a hang counts as a mismatch and ends in the same report
	always @(negedge clock) begin
		cycles++;
		if (cycles == 90000) begin
			mismatches++;
			close_out();
		end
	end

	// a result is a rise of the complete flag; ticks are counted while busy
	always @(negedge clock) begin
		if (exec_busy === 1'b1) begin
			ticks += timing_tick;
			gap |= !pump_on;
			seen_cmd = exec_op.cmd;
		end
		if (status.ccf === 1'b1 && ccf_q === 1'b0 && notes.size() > 0) begin
			n = notes.pop_front();
			if (n.cmd != 8'h00)
				chk("cmd", seen_cmd, n.cmd);
			if (n.ticks != 15'h0000)
				chk("ticks", ticks, n.ticks);
			chk("err at ccf", status.access_error_flag, n.err);
			if (n.hold)
				chk("pump gap", gap, 1'b0);
			ticks = 0;
			gap = 1'b0;
		end else if (status.ccf === 1'b1 && ccf_q === 1'b0) begin
			chk("ccf without note", 1'b1, 1'b0);
		end
		ccf_q = status.ccf;
	end

	initial begin
		static logic [7:0] codes [4] = '{8'h05, 8'h41, 8'h40, 8'h20};
		static logic [14:0] cnt [4] = '{15'h0001, 15'h4E20, 15'h0FA0, 15'h0009};
		logic [16:0] a;
		logic [7:0] d;
		void'($urandom(32'hD8BF));
		repeat (16) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		chk("status", status, 4'hC);
		cpu.put(2'h0, 17'h00010, 8'h5A, 1'b0);
		settle_err(1'b1);
		cpu.put(2'h3, 17'h0, 8'h02, 1'b0);
		settle_err(1'b0);
		cpu.put(2'h1, 17'h0, 8'h01, 1'b0);
		cpu.put(2'h1, 17'h0, 8'h07, 1'b0);
		repeat (2) @(negedge clock);
		chk("divider", clock_divider_reg, 8'h01);
		chk("div_set", status.div_set, 1'b1);
		// settling time before the first program or erase
		repeat (2000) @(negedge clock);
		$display("test setup done");
		// blank check first, then both erases, so the byte program lands on erased cells
		for (int k = 0; k < 4; k++) begin
			a = 17'($urandom);
			d = 8'($urandom);
			notes.push_back('{codes[k], cnt[k], 1'b0, 1'b0});
			launch(codes[k], k[0], a, d);
			wait_on(1'b1, 1'b0);
			wait_on(1'b1, 1'b1);
			chk("addr", exec_op.addr, a);
			chk("data", exec_op.data, d);
			chk("array", exec_op.eeprom, k[0]);
		end
		$display("test codes done");
		for (int j = 0; j < 3; j++) begin
			cpu.put(2'h0, a, d, 1'b0);
			if (j == 2) begin
				@(negedge clock);
				ctrl_access = 1'b1;
				@(negedge clock);
				ctrl_access = 1'b0;
			end else begin
				cpu.put(j ? 2'h3 : 2'h2, a, j ? 8'h00 : 8'h21, 1'b0);
			end
			settle_err(1'b1);
			cpu.put(2'h3, 17'h0, 8'h02, 1'b0);
			settle_err(1'b0);
		end
		// stop entry cuts a running byte program short
		notes.push_back('{8'h20, 15'h0000, 1'b1, 1'b0});
		launch(8'h20, 1'b1, ~a, d);
		repeat (6) @(negedge clock);
		stop_entry = 1'b1;
		@(negedge clock);
		stop_entry = 1'b0;
		chk("busy after stop", exec_busy, 1'b0);
		chk("pump after stop", pump_on, 1'b0);
		cpu.put(2'h3, 17'h0, 8'h02, 1'b0);
		settle_err(1'b0);
		$display("test errors done");
		for (int j = 0; j < 2; j++) begin
			a = j ? 17'h0041F : 17'h00400;
			notes.push_back('{8'h25, j ? 15'h0012 : 15'h000D, 1'b0, j == 0});
			launch(8'h25, 1'b0, a, d);
			wait_on(1'b0, 1'b0);
			wait_on(1'b0, 1'b1);
			launch(8'h25, 1'b0, a + 17'h1, ~d);
			wait_on(1'b1, 1'b1);
			repeat (2) @(negedge clock);
			chk("pump", pump_on, 1'b0);
		end
		$display("test burst done");
		notes.push_back('{8'h00, 15'h0000, 1'b1, 1'b0});
		launch(8'h40, 1'b1, a, d);
		wait_on(1'b0, 1'b0);
		wait_on(1'b0, 1'b1);
		launch(8'h47, 1'b0, ~a, ~d);
		repeat (4) @(negedge clock);
		chk("cbef", status.cbef, 1'b0);
		wait_on(1'b1, 1'b1);
		cpu.put(2'h3, 17'h0, 8'h02, 1'b0);
		settle_err(1'b0);
		$display("test abort done");
		chk("notes left", notes.size(), 0);
		close_out();
	end
endmodule : tb_top
